// [rtl/dp_pinmux.sv]
`timescale 1ns/1ps
module dp_pinmux (
  // Port settings
  input  wire logic [5:0]          dir,
  input  wire logic [5:0]          data,
  // Serial channels
  input  wire dp_pkg::dp_ser_ctl_s ch0,
  input  wire dp_pkg::dp_ser_ctl_s ch1,
  input  wire logic [1:0]          ser_clk_out,
  input  wire logic [1:0]          ser_tx,
  // Pin drive
  output wire logic [5:0]          pin_o,
  output wire logic [5:0]          pin_oe
);
  dp_pkg::dp_ser_ctl_s ch [2];
  assign ch[0] = ch0;
  assign ch[1] = ch1;

  // Index 0 is channel 0, index 1 channel 1
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ch
      logic [2:0] o_c;
      logic [2:0] oe_c;

      // Bit 2 clock pin, bit 1 receive pin, bit 0 transmit pin
      always_comb begin
        if (ch[i].ext_clk_in_en) begin
          o_c[2]  = 1'b0;
          oe_c[2] = 1'b0; // see R9
        end else if (ch[i].sync_mode || ch[i].int_clk_out_en) begin
          o_c[2]  = ser_clk_out[i];
          oe_c[2] = 1'b1; // see R9
        end else begin
          o_c[2]  = data[4+i]; // see R17
          oe_c[2] = dir[4+i]; // see R2
        end
        if (ch[i].rx_en) begin
          o_c[1]  = 1'b0;
          oe_c[1] = 1'b0; // see R10
        end else begin
          o_c[1]  = data[2+i];
          oe_c[1] = dir[2+i];
        end
        if (ch[i].tx_en) begin
          o_c[0]  = ser_tx[i];
          oe_c[0] = 1'b1; // see R10
        end else begin
          o_c[0]  = data[i];
          oe_c[0] = dir[i];
        end
      end

      assign pin_o[4+i]  = o_c[2];
      assign pin_oe[4+i] = oe_c[2];
      assign pin_o[2+i]  = o_c[1];
      assign pin_oe[2+i] = oe_c[1];
      assign pin_o[i]    = o_c[0];
      assign pin_oe[i]   = oe_c[0];
    end
  endgenerate
endmodule // dp_pinmux

// [rtl/dp_pkg.sv]
// Summary of operation
// R1: The six-bit port has six two-way pins, bits 5 to 0, whose functions are the same in every mode.
// R2: On the six-bit port a direction bit of 1 makes its pin an output and 0 makes it an input.
// R3: The six-bit port direction register is write-only and reads back as all ones.
// R4: The six-bit port direction register loads C0 on reset and hardware standby and holds through software standby.
// R5: In software standby every pin whose direction bit is 1 keeps driving its previous output level.
// R6: A read of the six-bit port data gives the stored bit for output pins and the live pin level for input pins.
// R7: Bits 7 and 6 of the six-bit port data register ignore writes and always read 1.
// R8: The six-bit port data register loads C0 on reset and hardware standby and holds in software standby.
// R9: Pins 5 and 4 carry the serial clocks: input when external clock is enabled, else output in clocked mode or with clock output enabled, else plain port; the interrupt input stays connected.
// R10: Pins 3 and 2 are receive inputs while receive is enabled, pins 1 and 0 transmit outputs while transmit is enabled, else plain port.
// R11: The eight-bit port has eight two-way pins, a direction bit of 1 making an output and 0 an input.
// R12: The eight-bit port direction register is write-only and reads back as all ones.
// R13: The eight-bit port direction register loads 00 in modes 1, 2, 5, 6, 7 and 80 in modes 3 and 4 on reset or hardware standby, and holds in software standby.
// R14: In modes 3 and 4 the direction bit of eight-bit pin 7 is held at 1 and the pin drives an address output.
// R15: A read of the eight-bit port data gives the stored bit for output pins and the sampled pin level for input pins.
// R16: The eight-bit port data register is read-write, loads 00 on reset and hardware standby and holds in software standby.
// R17: A plain output pin drives its stored data bit, and data writes update the stored bit even while the pin is an input.
package dp_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [15:0] OFS_SIX_DIR   = 16'hFFD0;
  localparam logic [15:0] OFS_EIGHT_DIR = 16'hFFD1;
  localparam logic [15:0] OFS_SIX_DATA  = 16'hFFD2;
  localparam logic [15:0] OFS_EIGHT_DATA = 16'hFFD3;
  localparam logic [7:0]  SIX_DIR_RST   = 8'hC0;
  localparam logic [7:0]  SIX_DATA_RST  = 8'hC0;
  localparam logic [7:0]  SIX_RSVD_MASK = 8'hC0;
  localparam logic [7:0]  EIGHT_DIR_RST_LO = 8'h00;
  localparam logic [7:0]  EIGHT_DIR_RST_HI = 8'h80;
  localparam logic [7:0]  EIGHT_DATA_RST = 8'h00;
  localparam logic [7:0]  ALL_ONES      = 8'hFF;
  localparam logic [7:0]  PIN7_MASK     = 8'h80;
  localparam logic [2:0]  MODE_ADDR_A   = 3'h3;
  localparam logic [2:0]  MODE_ADDR_B   = 3'h4;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  // Edges after reset release until the mode synchroniser holds the pin value
  localparam logic [1:0]  MODE_SETTLE   = 2'h2;

  // Serial channel controls for one channel
  typedef struct packed {
    logic ext_clk_in_en;
    logic int_clk_out_en;
    logic sync_mode;
    logic rx_en;
    logic tx_en;
  } dp_ser_ctl_s;

  // Bus slave state
  typedef struct packed {
    logic        wr_pend;
    logic        rd_pend;
    logic [15:0] addr;
    logic [31:0] rdata;
  } dp_bus_s;

  // Port register state
  typedef struct packed {
    logic [7:0] six_dir;
    logic [7:0] six_data;
    logic [7:0] eight_dir;
    logic [7:0] eight_data;
    logic       mode_ab;
    logic       init_done;
  } dp_regs_s;
endpackage

// [rtl/dp_port.sv]
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dp_port (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Chip state
  input  wire logic [2:0]          op_mode,
  input  wire logic                hw_standby,
  input  wire logic                sw_standby,
  // Serial channels
  input  wire dp_pkg::dp_ser_ctl_s ser_ctl0,
  input  wire dp_pkg::dp_ser_ctl_s ser_ctl1,
  input  wire logic [1:0]          ser_clk_out,
  input  wire logic [1:0]          ser_tx,
  output logic      [1:0]          ser_clk_in,
  output logic      [1:0]          ser_rx,
  output logic      [1:0]          ext_irq,
  // Address output for eight-bit pin 7
  input  wire logic                addr_bit_out,
  // Six-bit port pins
  input  wire logic [5:0]          six_pin_i,
  output logic      [5:0]          six_pin_o,
  output logic      [5:0]          six_pin_oe,
  // Eight-bit port pins
  input  wire logic [7:0]          eight_pin_i,
  output logic      [7:0]          eight_pin_o,
  output logic      [7:0]          eight_pin_oe
);
  typedef struct packed {
    dp_pkg::dp_bus_s  bus;
    dp_pkg::dp_regs_s regs;
    logic [5:0]       six_o;
    logic [5:0]       six_oe;
    logic [7:0]       eight_o;
    logic [7:0]       eight_oe;
    logic [1:0]       init_cnt;
  } dp_state_s;

  dp_state_s  st_q;
  dp_state_s  st_d;
  logic [5:0] six_sync;
  logic [7:0] eight_sync;
  logic [5:0] mux_o;
  logic [5:0] mux_oe;
  logic [2:0] mode_sync;
  logic       hws_sync;
  logic       sws_sync;
  logic       mode_ab_now;
  logic [7:0] six_rd;
  logic [7:0] eight_rd;
  logic [7:0] eight_dir_eff;
  logic [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  dp_sync #(.WIDTH(6)) u_sync_six (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (six_pin_i),
    .q       (six_sync)
  );

  dp_sync #(.WIDTH(8)) u_sync_eight (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (eight_pin_i),
    .q       (eight_sync)
  );

  dp_sync #(.WIDTH(5)) u_sync_ctl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({op_mode, hw_standby, sw_standby}),
    .q       ({mode_sync, hws_sync, sws_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // Six-bit port alternate functions

  dp_pinmux u_pinmux (
    .dir         (st_q.regs.six_dir[5:0]),
    .data        (st_q.regs.six_data[5:0]),
    .ch0         (ser_ctl0),
    .ch1         (ser_ctl1),
    .ser_clk_out (ser_clk_out),
    .ser_tx      (ser_tx),
    .pin_o       (mux_o),
    .pin_oe      (mux_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file and pin drive

  assign mode_ab_now   = (mode_sync == dp_pkg::MODE_ADDR_A) || (mode_sync == dp_pkg::MODE_ADDR_B);
  assign eight_dir_eff = st_q.regs.mode_ab ? (st_q.regs.eight_dir | dp_pkg::PIN7_MASK)
                                           : st_q.regs.eight_dir; // see R14
  assign six_rd   = dp_pkg::SIX_RSVD_MASK
                  | ({2'b00, st_q.regs.six_dir[5:0]  & st_q.regs.six_data[5:0]})
                  | ({2'b00, ~st_q.regs.six_dir[5:0] & six_sync}); // see R6 R7
  assign eight_rd = (eight_dir_eff & st_q.regs.eight_data)
                  | (~eight_dir_eff & eight_sync); // see R15
  assign wbyte    = hwdata[7:0];

  always_comb begin
    st_d = st_q;
    st_d.bus.wr_pend = 1'b0;
    st_d.bus.rd_pend = 1'b0;
    // Mode is caught once its synchroniser has settled after reset release
    if (!st_q.regs.init_done) begin
      st_d.regs.mode_ab   = mode_ab_now;
      st_d.regs.eight_dir = mode_ab_now ? dp_pkg::EIGHT_DIR_RST_HI : dp_pkg::EIGHT_DIR_RST_LO; // see R13
      if (st_q.init_cnt == dp_pkg::MODE_SETTLE) begin
        st_d.regs.init_done = 1'b1;
      end else begin
        st_d.init_cnt = 2'(st_q.init_cnt + 2'h1);
      end
    end
    // Data phase write
    if (st_q.bus.wr_pend) begin
      case (st_q.bus.addr)
        dp_pkg::OFS_SIX_DIR:    st_d.regs.six_dir    = wbyte | dp_pkg::SIX_RSVD_MASK; // see R2
        dp_pkg::OFS_EIGHT_DIR:  st_d.regs.eight_dir  = wbyte; // see R11
        dp_pkg::OFS_SIX_DATA:   st_d.regs.six_data   = wbyte | dp_pkg::SIX_RSVD_MASK; // see R7 R17
        dp_pkg::OFS_EIGHT_DATA: st_d.regs.eight_data = wbyte; // see R16 R17
        default:                st_d.regs            = st_d.regs;
      endcase
    end
    // Address phase
    if (hsel && hready && (htrans == dp_pkg::HTRANS_NONSEQ)) begin
      st_d.bus.addr    = haddr[17:2];
      st_d.bus.wr_pend = hwrite;
      st_d.bus.rd_pend = !hwrite;
      // One register per word, on the low byte
      case (haddr[17:2])
        dp_pkg::OFS_SIX_DIR:    st_d.bus.rdata = {24'h000000, dp_pkg::ALL_ONES}; // see R3
        dp_pkg::OFS_EIGHT_DIR:  st_d.bus.rdata = {24'h000000, dp_pkg::ALL_ONES}; // see R12
        dp_pkg::OFS_SIX_DATA:   st_d.bus.rdata = {24'h000000, six_rd};
        dp_pkg::OFS_EIGHT_DATA: st_d.bus.rdata = {24'h000000, eight_rd};
        default:                st_d.bus.rdata = '0;
      endcase
    end
    // Pins freeze in software standby
    if (!sws_sync) begin
      st_d.six_o    = mux_o; // see R1 R9 R10
      st_d.six_oe   = mux_oe;
      st_d.eight_o  = st_q.regs.mode_ab ? {addr_bit_out, st_q.regs.eight_data[6:0]}
                                        : st_q.regs.eight_data; // see R14 R17
      st_d.eight_oe = eight_dir_eff; // see R11
    end // see R5
    // Hardware standby acts as reset of the registers
    if (hws_sync) begin
      st_d.regs.six_dir    = dp_pkg::SIX_DIR_RST; // see R4
      st_d.regs.six_data   = dp_pkg::SIX_DATA_RST; // see R8
      st_d.regs.eight_data = dp_pkg::EIGHT_DATA_RST; // see R16
      st_d.regs.eight_dir  = mode_ab_now ? dp_pkg::EIGHT_DIR_RST_HI : dp_pkg::EIGHT_DIR_RST_LO; // see R13
      st_d.regs.mode_ab    = mode_ab_now;
      st_d.six_oe          = '0;
      st_d.eight_oe        = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q                 <= '0;
      st_q.regs.six_dir    <= dp_pkg::SIX_DIR_RST; // see R4
      st_q.regs.six_data   <= dp_pkg::SIX_DATA_RST; // see R8
      st_q.regs.eight_dir  <= dp_pkg::EIGHT_DIR_RST_LO;
      st_q.regs.eight_data <= dp_pkg::EIGHT_DATA_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata       = st_q.bus.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign six_pin_o    = st_q.six_o;
  assign six_pin_oe   = st_q.six_oe;
  assign eight_pin_o  = st_q.eight_o;
  assign eight_pin_oe = st_q.eight_oe;
  assign ser_clk_in   = six_sync[5:4]; // see R9
  assign ser_rx       = six_sync[3:2]; // see R10
  assign ext_irq      = six_sync[5:4]; // see R9

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_dir_write(logic [15:0] a);
    hsel && hready && htrans == dp_pkg::HTRANS_NONSEQ && hwrite && haddr[17:2] == a;
  endsequence

  a_six_dir_reads: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans == dp_pkg::HTRANS_NONSEQ && !hwrite && haddr[17:2] == dp_pkg::OFS_SIX_DIR)
    |=> hrdata[7:0] == dp_pkg::ALL_ONES) else $error("six dir read not ones"); // see R3
  a_eight_dir_reads: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans == dp_pkg::HTRANS_NONSEQ && !hwrite && haddr[17:2] == dp_pkg::OFS_EIGHT_DIR)
    |=> hrdata[7:0] == dp_pkg::ALL_ONES) else $error("eight dir read not ones"); // see R12
  a_six_rsvd_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.regs.six_data & dp_pkg::SIX_RSVD_MASK) == dp_pkg::SIX_RSVD_MASK) else $error("reserved bits lost"); // see R7
  a_six_dir_write: assert property (@(posedge hclk) disable iff (!hresetn || hws_sync)
    s_dir_write(dp_pkg::OFS_SIX_DIR) ##1 1'b1 |=> st_q.regs.six_dir[5:0] == $past(hwdata[5:0]))
    else $error("six dir write lost"); // see R2
  a_sw_hold_pins: assert property (@(posedge hclk) disable iff (!hresetn || hws_sync)
    sws_sync && !hws_sync |=> $stable(st_q.eight_o) && $stable(st_q.six_oe)) else $error("pins moved in standby"); // see R5
  a_pin7_output: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.regs.mode_ab && !sws_sync && !hws_sync |=> eight_pin_oe[7]) else $error("pin7 not output"); // see R14
  a_hw_standby: assert property (@(posedge hclk) disable iff (!hresetn)
    hws_sync |=> st_q.regs.six_dir == dp_pkg::SIX_DIR_RST && st_q.regs.eight_data == dp_pkg::EIGHT_DATA_RST)
    else $error("standby reset missing"); // see R4
  a_tx_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    ser_ctl0.tx_en && !sws_sync && !hws_sync |=> six_pin_oe[0] && six_pin_o[0] == $past(ser_tx[0]))
    else $error("tx pin not driven"); // see R10
  a_out_drives: assert property (@(posedge hclk) disable iff (!hresetn)
    !sws_sync && !hws_sync && !st_q.regs.mode_ab |=> eight_pin_o == $past(st_q.regs.eight_data))
    else $error("output not data"); // see R17
endmodule // dp_port

// [rtl/dp_sync.sv]
`timescale 1ns/1ps
module dp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // dp_sync

// [tb/dp_board.sv]
`timescale 1ns/1ps
module dp_board (
  // Design drive
  input  wire logic [5:0] six_o,
  input  wire logic [5:0] six_oe,
  input  wire logic [7:0] eight_o,
  input  wire logic [7:0] eight_oe,
  // Board sources
  input  wire logic [5:0] six_ext,
  input  wire logic [7:0] eight_ext,
  // Wire levels
  output logic      [5:0] six_lvl,
  output logic      [7:0] eight_lvl
);
  // Driven pins follow the design, released pins the board source
  assign six_lvl   = (six_o & six_oe) | (six_ext & ~six_oe);
  assign eight_lvl = (eight_o & eight_oe) | (eight_ext & ~eight_oe);
endmodule // dp_board

// [tb/dp_port_test.sv]
`timescale 1ns/1ps
module dp_port_test;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, hw_sb, sw_sb, abit, mab;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [1:0]          htrans, sck_o, tx, sck_i, rx, irq;
  logic [2:0]          op_mode;
  dp_pkg::dp_ser_ctl_s c0, c1;
  logic [5:0]          s_o, s_oe, s_lvl, s_ext;
  logic [7:0]          e_o, e_oe, e_lvl, e_ext, s_dir, s_dat, e_dir, e_dat, v;
  logic [11:0]         snap;
  int                  error_cnt, checked, cyc, seed, i;

  dp_port dp_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode), .hw_standby(hw_sb), .sw_standby(sw_sb),
    .ser_ctl0(c0), .ser_ctl1(c1), .ser_clk_out(sck_o), .ser_tx(tx), .ser_clk_in(sck_i), .ser_rx(rx),
    .ext_irq(irq), .addr_bit_out(abit), .six_pin_i(s_lvl), .six_pin_o(s_o), .six_pin_oe(s_oe),
    .eight_pin_i(e_lvl), .eight_pin_o(e_o), .eight_pin_oe(e_oe));
  dp_board dp_board_i (.six_o(s_o), .six_oe(s_oe), .eight_o(e_o), .eight_oe(e_oe), .six_ext(s_ext),
    .eight_ext(e_ext), .six_lvl(s_lvl), .eight_lvl(e_lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, a, 2'b00};
    htrans <= dp_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
    case (a)
      dp_pkg::OFS_SIX_DIR:    s_dir = d | 8'hC0;
      dp_pkg::OFS_EIGHT_DIR:  e_dir = d | (mab ? 8'h80 : 8'h00);
      dp_pkg::OFS_SIX_DATA:   s_dat = d | 8'hC0;
      dp_pkg::OFS_EIGHT_DATA: e_dat = d;
      default: ;
    endcase
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk("read", {22'h000000, hreadyout, hresp, x}, {22'h000000, 2'b10, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] mux_exp();
    dp_pkg::dp_ser_ctl_s c;
    logic [5:0]          oe, o;
    oe = s_dir[5:0];
    o  = s_dat[5:0];
    for (int k = 0; k < 2; k++) begin
      c = k ? c1 : c0;
      if (c.ext_clk_in_en)
        oe[4+k] = 1'b0;
      else if (c.sync_mode | c.int_clk_out_en) begin
        oe[4+k] = 1'b1;
        o[4+k]  = sck_o[k];
      end
      if (c.rx_en)
        oe[2+k] = 1'b0;
      if (c.tx_en) begin
        oe[k] = 1'b1;
        o[k]  = tx[k];
      end
    end
    return {oe, o & oe};
  endfunction

  function automatic logic [7:0] sx();
    return 8'hC0 | (((s_dat & s_dir) | ({2'b00, s_ext} & ~s_dir)) & 8'h3F);
  endfunction

  task automatic pins();
    logic [7:0] eo;
    repeat (5) @(posedge hclk);
    eo = e_dat & e_dir;
    if (mab)
      eo[7] = abit;
    chk("six pins", {20'h00000, s_oe, s_o & s_oe}, {20'h00000, mux_exp()});
    chk("eight pins", {16'h0000, e_oe, e_o & e_oe}, {16'h0000, e_dir, eo});
    chk("serial in", {26'h0, sck_i, rx, irq}, {26'h0, s_lvl[5:2], s_lvl[5:4]});
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, hw_sb, sw_sb, abit, htrans, sck_o, tx, c0, c1} = '0;
    {haddr, hwdata, error_cnt, checked, cyc} = '0;
    seed = 32'h788F8898;
    op_mode = 3'h1;
    mab = 1'b0;
    s_ext = 6'h2A;
    e_ext = 8'h5C;
    {s_dir, s_dat, e_dir, e_dat} = {8'hC0, 8'hC0, 8'h00, 8'h00};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    pins();
    rchk(dp_pkg::OFS_SIX_DIR, 8'hFF);
    rchk(dp_pkg::OFS_EIGHT_DIR, 8'hFF);
    rchk(dp_pkg::OFS_SIX_DATA, sx());
    rchk(dp_pkg::OFS_EIGHT_DATA, e_ext);
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      s_ext <= 6'($random(seed));
      e_ext <= 8'($random(seed));
      wr(dp_pkg::OFS_SIX_DATA, 8'($random(seed)));
      wr(dp_pkg::OFS_EIGHT_DATA, 8'($random(seed)));
      wr(dp_pkg::OFS_SIX_DIR, 8'($random(seed)));
      wr(dp_pkg::OFS_EIGHT_DIR, 8'($random(seed)));
      pins();
      rchk(dp_pkg::OFS_SIX_DATA, sx());
      rchk(dp_pkg::OFS_EIGHT_DATA, (e_dat & e_dir) | (e_ext & ~e_dir));
      rchk(dp_pkg::OFS_SIX_DIR, 8'hFF);
    end
    wr(16'hFFD4, 8'hA5);
    rchk(16'hFFD4, 8'h00);
    $display("test ports done");
    for (i = 0; i < 16; i++) begin
      c0    <= 5'($random(seed));
      c1    <= 5'($random(seed));
      sck_o <= 2'($random(seed));
      tx    <= 2'($random(seed));
      s_ext <= 6'($random(seed));
      pins();
    end
    {c0, c1} <= '0;
    $display("test serial done");
    wr(dp_pkg::OFS_SIX_DIR, 8'h3F);
    wr(dp_pkg::OFS_SIX_DATA, 8'h15);
    pins();
    snap  = {s_oe, s_o};
    sw_sb <= 1'b1;
    repeat (4) @(posedge hclk);
    c0.tx_en <= 1'b1;
    tx       <= 2'b00;
    repeat (5) @(posedge hclk);
    chk("standby pins", {20'h00000, s_oe, s_o}, {20'h00000, snap});
    sw_sb <= 1'b0;
    c0    <= '0;
    repeat (5) @(posedge hclk);
    rchk(dp_pkg::OFS_SIX_DATA, 8'hD5);
    rchk(dp_pkg::OFS_EIGHT_DATA, (e_dat & e_dir) | (e_ext & ~e_dir));
    pins();
    $display("test sw standby done");
    op_mode <= dp_pkg::MODE_ADDR_A;
    hw_sb   <= 1'b1;
    repeat (6) @(posedge hclk);
    hw_sb <= 1'b0;
    repeat (6) @(posedge hclk);
    mab = 1'b1;
    {s_dir, s_dat, e_dir, e_dat} = {8'hC0, 8'hC0, 8'h80, 8'h00};
    pins();
    wr(dp_pkg::OFS_EIGHT_DIR, 8'h00);
    wr(dp_pkg::OFS_EIGHT_DATA, 8'h7E);
    abit <= 1'b1;
    pins();
    rchk(dp_pkg::OFS_EIGHT_DATA, (e_dat & e_dir) | (e_ext & ~e_dir));
    rchk(dp_pkg::OFS_SIX_DATA, sx());
    $display("test hw standby done");
    wrap_up();
  end
endmodule // dp_port_test
